// ===== fop_flash_model.sv
/* fop_flash_model: flash array stand-in counting the strobes it gets.
   assumes: strobes are one-cycle pulses on aclk; it never stalls. */
`timescale 1ns/10ps
module fop_flash_model
    import fop_pkg::*;
(
    input  wire logic           aclk,
    input  wire fop_flash_req_t flash_req,
    output int                  n_ops = 0,
    output int                  n_mass = 0,
    output logic [31:0]         last_addr = 32'h0000_0000
);
    // count what the array would really carry out
    always @(posedge aclk) begin
        if (flash_req.prog || flash_req.page_erase || flash_req.mass_erase) begin
            n_ops <= n_ops + 1;
            last_addr <= flash_req.addr;
        end
        if (flash_req.mass_erase) begin
            n_mass <= n_mass + 1;
        end
    end
endmodule

// ===== fop_optmem.sv
/*
 * fop_optmem: storage of the eight option byte half-words of the user
 * info page, read data registered.
 * assumes: one write or read per cycle, synchronous reset leaves content.
 */
`timescale 1ns/10ps
module fop_optmem
    import fop_pkg::*;
(
    input  wire logic         aclk,
    input  wire fop_opt_req_t req,
    output logic [15:0]       rdata
);

    // ------------------------------------------------------------
    // storage, initially erased
    // ------------------------------------------------------------
    logic [15:0] mem_r [FOP_NUM_OPT];   // half-word array
    logic [15:0] rdata_r;               // registered read data

    initial begin
        for (int i = 0; i < FOP_NUM_OPT; i++) begin
            mem_r[i] = FOP_ERASED_HALF;
        end
    end

    // write side and registered read
    always_ff @(posedge aclk) begin
        if (req.we) begin
            mem_r[req.idx] <= req.wdata;
        end
        rdata_r <= mem_r[req.idx];
    end

    assign rdata = rdata_r;

endmodule

// ===== fop_pkg.sv
/*
 * fop_pkg: constants and carrier types of the flash option protection block.
 * assumes: used by fop_top and fop_optmem; one clock aclk, sync reset aresetn.
 */
package fop_pkg;

    // ------------------------------------------------------------
    // option byte layout and addresses
    // ------------------------------------------------------------
    localparam int          FOP_NUM_OPT         = 8;
    localparam logic [31:0] FOP_OPT_BASE_ADDR   = 32'h0804_0800;
    localparam logic [31:0] FOP_MAIN_BASE_ADDR  = 32'h0800_0000;
    localparam logic [31:0] FOP_MAIN_END_ADDR   = 32'h0803_0000;
    localparam int          FOP_REGION_SHIFT    = 13;
    localparam int          FOP_PAGE_SHIFT      = 11;
    localparam int          FOP_PAGES_PER_REGION = 4;
    localparam int          FOP_REGIONS_SMALL   = 16;
    localparam int          FOP_REGIONS_LARGE   = 24;
    localparam logic [7:0]  FOP_RDP_OFF_VALUE   = 8'hA5;
    localparam logic [7:0]  FOP_ERASED_BYTE     = 8'hFF;
    localparam logic [15:0] FOP_ERASED_HALF     = 16'hFFFF;
    localparam logic [2:0]  FOP_IDX_RDP         = 3'h0;
    localparam logic [2:0]  FOP_IDX_USER0       = 3'h2;
    localparam logic [2:0]  FOP_IDX_USER1       = 3'h3;
    localparam logic [2:0]  FOP_IDX_WRP0        = 3'h4;
    localparam logic [2:0]  FOP_IDX_WRP1        = 3'h5;
    localparam logic [2:0]  FOP_IDX_WRP2        = 3'h6;
    localparam logic [2:0]  FOP_IDX_LAST        = 3'h7;

    // ------------------------------------------------------------
    // axi4-lite register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0]  FOP_REG_STATUS      = 8'h00;
    localparam logic [7:0]  FOP_REG_WRPROT      = 8'h04;
    localparam logic [7:0]  FOP_REG_USER        = 8'h08;
    localparam logic [7:0]  FOP_REG_CMD         = 8'h0C;
    localparam logic [7:0]  FOP_REG_ADDR        = 8'h10;
    localparam logic [7:0]  FOP_REG_DATA        = 8'h14;
    localparam logic [7:0]  FOP_REG_OPT_RAW     = 8'h18;
    localparam logic [1:0]  FOP_RESP_OKAY       = 2'h0;
    localparam logic [1:0]  FOP_RESP_SLVERR     = 2'h2;
    localparam logic [1:0]  FOP_RESP_DECERR     = 2'h3;

    // command codes written to FOP_REG_CMD
    localparam logic [1:0]  FOP_CMD_PROG        = 2'h1;
    localparam logic [1:0]  FOP_CMD_ERASE       = 2'h2;
    localparam logic [1:0]  FOP_CMD_OPT_ERASE   = 2'h3;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FOP_ST_LOAD  = 2'h0,
        FOP_ST_CHECK = 2'h1,
        FOP_ST_RUN   = 2'h2,
        FOP_ST_FAULT = 2'h3
    } fop_state_t;

    // request towards the flash array
    typedef struct packed {
        logic        prog;
        logic        page_erase;
        logic        mass_erase;
        logic [31:0] addr;
        logic [15:0] data;
    } fop_flash_req_t;

    // option byte memory port
    typedef struct packed {
        logic        we;
        logic [2:0]  idx;
        logic [15:0] wdata;
    } fop_opt_req_t;

endpackage

// ===== fop_top.sv
/*
 * fop_top: flash read and write protection from option bytes.
 * assumes: axi4-lite master for software; flash array takes requests on
 * flash_req; debug_connected and ext_reset_pin come from pins.
 */
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
// Notes on behaviour
// - option byte is value plus hardware inverse
// - inverse mismatch at reset halts the cpu
// - option bytes start at user page base
// - each protect bit guards four pages
// - small part 16 regions, large 24
// - protect bits active low, 0xFF unprotected
// - new protect bytes act after reset only
// - protected region refuses program and erase
// - byte 4/5/6 bit 0 at fixed bases
// - byte 0 governs read protection everywhere
// - only 0xA5 disables read protection
// - read protection state changes only on reset
// - debugger connection latches intrusion flag
// - protection plus intrusion detaches all flash
// - intrusion clears only by pin reset unattached
// - erasing byte 0 protected mass-erases array
// - read protection guards lowest four pages
// - bytes 2,3 plain data; 1,7 reserved
module fop_top
    import fop_pkg::*;
#(
    parameter bit LARGE = 1'b1          // 1: 24 regions, 0: 16 regions
)(
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         ext_reset_pin,   // reset came from the pin
    input  wire logic         debug_connected,
    input  wire logic [31:0]  s_axi_awaddr,
    input  wire logic         s_axi_awvalid,
    output logic              s_axi_awready,
    input  wire logic [31:0]  s_axi_wdata,
    input  wire logic [3:0]   s_axi_wstrb,
    input  wire logic         s_axi_wvalid,
    output logic              s_axi_wready,
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  wire logic         s_axi_bready,
    input  wire logic [31:0]  s_axi_araddr,
    input  wire logic         s_axi_arvalid,
    output logic              s_axi_arready,
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  wire logic         s_axi_rready,
    output fop_flash_req_t    flash_req,
    output logic              flash_detach,    // flash cut from bus
    output logic              cpu_halt         // option byte error
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        fop_state_t     st;
        logic [2:0]     idx;         // option byte being loaded
        logic           rd_pend;     // memory read in flight
        logic [7:0]     opt0;
        logic [7:0]     opt2;
        logic [7:0]     opt3;
        logic [23:0]    wrp_n;       // active-low protect bits
        logic           rdp;
        logic           intr;
        logic [2:0]     dbg_s;       // debug pin synchroniser
        logic [2:0]     pin_s;       // reset source synchroniser
        logic           aw_got;
        logic           w_got;
        logic [7:0]     awaddr;
        logic [31:0]    wdata;
        logic           bvalid;
        logic [1:0]     bresp;
        logic           arready;
        logic           rvalid;
        logic [31:0]    rdata;
        logic [1:0]     rresp;
        logic [31:0]    cmd_addr;
        logic [15:0]    cmd_data;
        logic [1:0]     refused;     // last command refused, cleared by next command
        fop_flash_req_t freq;
        fop_opt_req_t   oreq;
        logic           detach;
        logic           halt;
    } fop_regs_t;

    fop_regs_t   s_r;               // registered state
    fop_regs_t   s_nxt;             // next state
    logic [15:0] opt_rdata;         // option memory read data
    logic        intr_keep_r;       // intrusion survives this reset

    // ------------------------------------------------------------
    // option byte memory
    // ------------------------------------------------------------
    fop_optmem u_optmem (
        .aclk  (aclk),
        .req   (s_nxt.oreq),
        .rdata (opt_rdata)
    );

    // ------------------------------------------------------------
    // region lookup: protected when bit low or rdp on first region
    // ------------------------------------------------------------
    function automatic logic addr_protected(input logic [31:0] a,
                                            input fop_regs_t s);
        logic [31:0] off;
        logic [4:0]  reg_i;
        logic        hit;
        off   = a - FOP_MAIN_BASE_ADDR;
        reg_i = off[FOP_REGION_SHIFT +: 5];
        hit   = 1'b0;
        if (a < FOP_MAIN_BASE_ADDR || a >= FOP_MAIN_END_ADDR) begin
            hit = 1'b0;
        end else if (!LARGE && reg_i >= 5'(FOP_REGIONS_SMALL)) begin
            hit = 1'b0;
        end else begin
            hit = !s.wrp_n[reg_i];
        end
        if (s.rdp && reg_i == 5'h00 && a >= FOP_MAIN_BASE_ADDR) begin
            hit = 1'b1;
        end
        return hit;
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] v;
        logic       wr_fire;
        v       = opt_rdata[7:0];
        wr_fire = 1'b0;
        s_nxt   = s_r;
        // synchronisers: three stages, change on stages 2 and 3 agreeing
        s_nxt.dbg_s = {s_r.dbg_s[1:0], debug_connected};
        s_nxt.pin_s = {s_r.pin_s[1:0], ext_reset_pin};
        if (s_r.dbg_s[1] && s_r.dbg_s[2]) begin
            s_nxt.intr = 1'b1;
        end
        // single-cycle strobes default low
        s_nxt.freq.prog       = 1'b0;
        s_nxt.freq.page_erase = 1'b0;
        s_nxt.freq.mass_erase = 1'b0;
        s_nxt.oreq.we         = 1'b0;
        s_nxt.arready         = 1'b0;

        case (s_r.st)
            FOP_ST_LOAD: begin
                // walk the eight half-words from the user page base
                s_nxt.oreq.idx = s_r.idx;
                s_nxt.rd_pend  = 1'b1;
                if (s_r.rd_pend) begin
                    s_nxt.st = FOP_ST_CHECK;
                end
            end
            FOP_ST_CHECK: begin
                s_nxt.rd_pend = 1'b0;
                // an erased half-word is legal and reads as byte 0xFF
                if (opt_rdata != FOP_ERASED_HALF && opt_rdata[15:8] != ~v) begin
                    s_nxt.st   = FOP_ST_FAULT;
                    s_nxt.halt = 1'b1;
                end else begin
                    case (s_r.idx)
                        FOP_IDX_RDP: begin
                            s_nxt.opt0 = v;
                            s_nxt.rdp  = (v != FOP_RDP_OFF_VALUE);
                        end
                        FOP_IDX_USER0: s_nxt.opt2 = v;
                        FOP_IDX_USER1: s_nxt.opt3 = v;
                        FOP_IDX_WRP0:  s_nxt.wrp_n[7:0]   = v;
                        FOP_IDX_WRP1:  s_nxt.wrp_n[15:8]  = v;
                        FOP_IDX_WRP2:
                            s_nxt.wrp_n[23:16] = LARGE ? v
                                               : FOP_ERASED_BYTE;
                        default: ;                         // reserved
                    endcase
                    if (s_r.idx == FOP_IDX_LAST) begin
                        s_nxt.st = FOP_ST_RUN;
                    end else begin
                        s_nxt.idx = s_r.idx + 3'h1;
                        s_nxt.st  = FOP_ST_LOAD;
                    end
                end
            end
            FOP_ST_RUN: begin
                // loaded state frozen here; only reset reloads it
                s_nxt.detach = s_r.rdp && s_nxt.intr;
            end
            FOP_ST_FAULT: begin
                s_nxt.halt = 1'b1;
            end
            default: s_nxt.st = FOP_ST_LOAD;
        endcase

        // ---------------- axi4-lite write channel ----------------
        if (s_axi_awvalid && !s_r.aw_got && !s_r.bvalid) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.awaddr = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && !s_r.w_got && !s_r.bvalid) begin
            s_nxt.w_got = 1'b1;
            s_nxt.wdata = s_axi_wdata;
        end
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
            wr_fire      = 1'b1;
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got  = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp  = FOP_RESP_OKAY;
        end
        if (wr_fire) begin
            case (s_r.awaddr)
                FOP_REG_ADDR: s_nxt.cmd_addr = s_r.wdata;
                FOP_REG_DATA: s_nxt.cmd_data = s_r.wdata[15:0];
                FOP_REG_CMD: begin
                    s_nxt.refused = 2'h0;
                    if (s_r.st != FOP_ST_RUN) begin
                        s_nxt.bresp = FOP_RESP_SLVERR;
                    end else if (s_r.wdata[1:0] == FOP_CMD_OPT_ERASE) begin
                        // option byte erase; value and inverse both written as 0xFF
                        s_nxt.oreq.we    = 1'b1;
                        s_nxt.oreq.idx   = s_r.cmd_addr[3:1];
                        s_nxt.oreq.wdata = FOP_ERASED_HALF;
                        if (s_r.cmd_addr[3:1] == FOP_IDX_RDP && s_r.rdp) begin
                            s_nxt.freq.mass_erase = 1'b1;
                        end
                    end else if (s_r.cmd_addr[31:4] == FOP_OPT_BASE_ADDR[31:4]
                                 && s_r.wdata[1:0] == FOP_CMD_PROG) begin
                        // program option byte: low byte plus inverse
                        s_nxt.oreq.we    = 1'b1;
                        s_nxt.oreq.idx   = s_r.cmd_addr[3:1];
                        s_nxt.oreq.wdata = {~s_r.cmd_data[7:0],
                                            s_r.cmd_data[7:0]};
                    end else if (addr_protected(s_r.cmd_addr, s_r)) begin
                        s_nxt.refused = 2'h1;
                        s_nxt.bresp   = FOP_RESP_SLVERR;
                    end else begin
                        s_nxt.freq.addr = s_r.cmd_addr;
                        s_nxt.freq.data = s_r.cmd_data;
                        s_nxt.freq.prog =
                            (s_r.wdata[1:0] == FOP_CMD_PROG);
                        s_nxt.freq.page_erase =
                            (s_r.wdata[1:0] == FOP_CMD_ERASE);
                    end
                end
                default: s_nxt.bresp = FOP_RESP_DECERR;
            endcase
        end

        // ---------------- axi4-lite read channel ----------------
        if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !s_r.arready && !s_r.rvalid) begin
            s_nxt.arready = 1'b1;
            s_nxt.rvalid  = 1'b1;
            s_nxt.rresp   = FOP_RESP_OKAY;
            case (s_axi_araddr[7:0])
                FOP_REG_STATUS:
                    s_nxt.rdata = {24'h000000, s_r.refused, s_r.halt,
                                   s_r.detach, s_r.intr, s_r.rdp, s_r.st};
                FOP_REG_WRPROT:  s_nxt.rdata = {8'h00, s_r.wrp_n};
                FOP_REG_USER:
                    s_nxt.rdata = {8'h00, s_r.opt0, s_r.opt3, s_r.opt2};
                FOP_REG_ADDR:    s_nxt.rdata = s_r.cmd_addr;
                FOP_REG_DATA:    s_nxt.rdata = {16'h0000, s_r.cmd_data};
                FOP_REG_CMD:     s_nxt.rdata = 32'h0000_0000;
                default: begin
                    s_nxt.rdata = 32'h0000_0000;
                    s_nxt.rresp = FOP_RESP_DECERR;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // register update; intrusion survives a reset not from the pin
    // or while the debugger is still attached
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r          <= '0;
            s_r.st       <= FOP_ST_LOAD;
            s_r.rdp      <= 1'b1;      // protected until loaded
            s_r.wrp_n    <= 24'hFFFFFF;
            s_r.detach   <= 1'b1;      // flash held off until loaded
            s_r.intr     <= intr_keep_r;
            s_r.dbg_s    <= s_nxt.dbg_s;
            s_r.pin_s    <= s_nxt.pin_s;
        end else begin
            s_r <= s_nxt;
        end
    end

    // intrusion memory across resets, cleared by pin reset unattached
    always_ff @(posedge aclk) begin
        if (!aresetn && s_r.pin_s[2] && s_r.pin_s[1]
            && !(s_r.dbg_s[2] && s_r.dbg_s[1])) begin
            intr_keep_r <= 1'b0;
        end else if (aresetn) begin
            intr_keep_r <= s_nxt.intr;
        end
    end

    // ------------------------------------------------------------
    // outputs, all from flip-flops
    // ------------------------------------------------------------
    assign s_axi_awready = s_r.aw_got;
    assign s_axi_wready  = s_r.w_got;
    assign s_axi_bvalid  = s_r.bvalid;
    assign s_axi_bresp   = s_r.bresp;
    assign s_axi_arready = s_r.arready;
    assign s_axi_rvalid  = s_r.rvalid;
    assign s_axi_rdata   = s_r.rdata;
    assign s_axi_rresp   = s_r.rresp;
    assign flash_req     = s_r.freq;
    assign flash_detach  = s_r.detach;
    assign cpu_halt      = s_r.halt;

endmodule

// ===== fop_top_monitor.sv
/* fop_top_monitor: port-level assertions for fop_top.
   assumes: bound into every fop_top; one clock, sync active-low reset. */
`timescale 1ns/10ps
module fop_top_monitor
    import fop_pkg::*;
#(
    parameter bit LARGE = 1'b1
)(
    input wire logic           aclk,
    input wire logic           aresetn,
    input wire logic           s_axi_awready,
    input wire logic [1:0]     s_axi_bresp,
    input wire logic           s_axi_bvalid,
    input wire logic           s_axi_bready,
    input wire logic [31:0]    s_axi_rdata,
    input wire logic           s_axi_rvalid,
    input wire logic           s_axi_rready,
    input wire fop_flash_req_t flash_req,
    input wire logic           flash_detach,
    input wire logic           cpu_halt
);
    // ----------------------------------------
    // helper logic
    // ----------------------------------------
    logic [4:0] run_r;    // edges since release, saturating
    logic [4:0] run_nxt;
    logic       stb;      // any flash strobe
    assign stb = flash_req.prog | flash_req.page_erase
               | flash_req.mass_erase;
    // saturate well past the option load so settled checks skip it
    always_comb begin
        run_nxt = (run_r == 5'h1F) ? run_r : run_r + 5'h01;
        if (!aresetn) begin
            run_nxt = 5'h00;
        end
    end
    always_ff @(posedge aclk) begin
        run_r <= run_nxt;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_settled;
        run_r == 5'h1F;
    endsequence
    sequence s_b_wait;
        s_axi_bvalid && !s_axi_bready;
    endsequence
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    AST_RESET_STATE: assert property ($rose(aresetn) |-> flash_detach
        && !s_axi_bvalid && !s_axi_rvalid && !stb)
        else $error("outputs not at reset values");
    AST_DETACH_HELD: assert property (s_settled |-> !$fell(flash_detach))
        else $error("flash reattached while running");
    AST_NO_HALT: assert property (s_settled |-> !cpu_halt)
        else $error("halt raised with hardware inverses");
    AST_ONE_STROBE: assert property ($onehot0({flash_req.prog,
        flash_req.page_erase, flash_req.mass_erase}))
        else $error("several flash strobes at once");
    AST_STROBE_OK: assert property (stb |-> $rose(s_axi_bvalid)
        && s_axi_bresp == FOP_RESP_OKAY)
        else $error("flash strobe without accepted command");
    AST_REGION0: assert property (s_settled ##0 (flash_detach
        && (flash_req.prog || flash_req.page_erase)) |->
        flash_req.addr[31:13] != FOP_MAIN_BASE_ADDR[31:13])
        else $error("lowest region changed under read protection");
    AST_B_HOLD: assert property (s_b_wait |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    AST_MASS_ONCE: assert property (flash_req.mass_erase |=> !stb [*2])
        else $error("mass erase repeated");
endmodule

bind fop_top fop_top_monitor #(.LARGE(LARGE)) u_mon (
    .aclk, .aresetn, .s_axi_awready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .flash_req, .flash_detach, .cpu_halt
);

// ===== tb_flash_option_protection.sv
/* tb_flash_option_protection: self-checking bench for fop_top.
   assumes: package, design, flash model and monitor compiled first. */
`timescale 1ns/10ps
module tb_flash_option_protection;
    import fop_pkg::*;
    logic           aclk, aresetn = 1'b0, ext_reset_pin = 1'b1;
    logic           debug_connected = 1'b0;
    logic [31:0]    awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
    logic           awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic           arvalid = 1'b0, rready = 1'b0;
    logic           awready, wready, bvalid, arready, rvalid;
    logic [1:0]     bresp, rresp;
    logic [31:0]    rdata, last_addr;
    fop_flash_req_t flash_req;
    logic           flash_detach, cpu_halt;
    int             n_ops, n_mass, failures = 0, compares = 0, n;
    fop_top #(.LARGE(1'b1)) u_dut (
        .aclk(aclk), .aresetn(aresetn), .ext_reset_pin(ext_reset_pin),
        .debug_connected(debug_connected), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .flash_req(flash_req),
        .flash_detach(flash_detach), .cpu_halt(cpu_halt));
    fop_flash_model u_flash (.aclk(aclk), .flash_req(flash_req),
        .n_ops(n_ops), .n_mass(n_mass), .last_addr(last_addr));
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    task automatic tally_and_finish();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one edge of a bounded wait; a hang ends the run
    task automatic guard(inout int k);
        @(posedge aclk);
        k++;
        if (k > 200) begin
            failures++;
            tally_and_finish();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        logic aw_p, w_p;
        int   k;
        k = 0;
        aw_p = 1'b1;
        w_p = 1'b1;
        awaddr <= {24'h000000, a};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (aw_p || w_p) begin
            guard(k);
            aw_p = aw_p && !awready;
            w_p = w_p && !wready;
            awvalid <= aw_p;
            wvalid <= w_p;
        end
        while (!bvalid) guard(k);
        chk("write resp", {30'h0, er}, {30'h0, bresp});
        bready <= 1'b1;
        guard(k);
        bready <= 1'b0;
    endtask
    // read, mask and compare one register
    task automatic rdc(input string nm, input logic [7:0] a,
                       input logic [31:0] m, input logic [31:0] e,
                       input logic [1:0] er);
        int k;
        k = 0;
        araddr <= {24'h000000, a};
        arvalid <= 1'b1;
        guard(k);
        while (!arready) guard(k);
        arvalid <= 1'b0;
        while (!rvalid) guard(k);
        chk("read resp", {30'h0, er}, {30'h0, rresp});
        chk(nm, e, rdata & m);
        rready <= 1'b1;
        guard(k);
        rready <= 1'b0;
    endtask
    // command with address and data; eo is the flash strobes expected
    task automatic cmd(input logic [1:0] c, input logic [31:0] a,
                       input logic [7:0] d, input logic [1:0] er, int eo);
        int b;
        b = n_ops;
        wr(FOP_REG_ADDR, a, FOP_RESP_OKAY);
        wr(FOP_REG_DATA, {24'h000000, d}, FOP_RESP_OKAY);
        wr(FOP_REG_CMD, {30'h0, c}, er);
        @(posedge aclk);
        chk("flash strobes", eo, n_ops - b);
    endtask
    // pin says whether the reset comes from the external pin
    task automatic do_reset(input logic pin);
        ext_reset_pin <= pin;
        aresetn <= 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        ext_reset_pin <= 1'b0;
        repeat (32) @(posedge aclk);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        do_reset(1'b1);
        rdc("status", FOP_REG_STATUS, 32'h3F, 32'h06, FOP_RESP_OKAY);
        rdc("wrprot", FOP_REG_WRPROT, 32'hFFFFFE, 32'hFFFFFE, 2'h0);
        cmd(FOP_CMD_PROG, 32'h0800_1FFE, 8'h12, FOP_RESP_SLVERR, 0);
        cmd(FOP_CMD_ERASE, 32'h0800_0000, 8'h00, FOP_RESP_SLVERR, 0);
        cmd(FOP_CMD_PROG, 32'h0800_2000, 8'h34, FOP_RESP_OKAY, 1);
        chk("flash addr", 32'h0800_2000, last_addr);
        rdc("unmapped", FOP_REG_OPT_RAW, 32'h0, 32'h0, FOP_RESP_DECERR);
        cmd(FOP_CMD_OPT_ERASE, FOP_OPT_BASE_ADDR, 8'h00, 2'h0, 1);
        chk("mass erases", 32'h1, n_mass);
        cmd(FOP_CMD_PROG, FOP_OPT_BASE_ADDR, 8'hA5, 2'h0, 0);
        cmd(FOP_CMD_PROG, 32'h0804_0808, 8'hFD, 2'h0, 0);
        cmd(FOP_CMD_PROG, 32'h0804_080C, 8'h7F, 2'h0, 0);
        cmd(FOP_CMD_PROG, 32'h0804_0804, 8'h3C, 2'h0, 0);
        cmd(FOP_CMD_PROG, 32'h0800_3800, 8'h56, 2'h0, 1);
        rdc("wrprot", FOP_REG_WRPROT, 32'hFFFFFE, 32'hFFFFFE, 2'h0);
        do_reset(1'b1);
        rdc("status", FOP_REG_STATUS, 32'h3F, 32'h02, 2'h0);
        rdc("wrprot", FOP_REG_WRPROT, 32'hFFFFFF, 32'h7FFFFD, 2'h0);
        rdc("user", FOP_REG_USER, 32'hFFFFFF, 32'hA5FF3C, 2'h0);
        cmd(FOP_CMD_ERASE, 32'h0800_3800, 8'h00, 2'h2, 0);
        cmd(FOP_CMD_PROG, 32'h0802_E000, 8'h01, 2'h2, 0);
        cmd(FOP_CMD_PROG, 32'h0800_0000, 8'h02, 2'h0, 1);
        debug_connected <= 1'b1;
        repeat (8) @(posedge aclk);
        debug_connected <= 1'b0;
        do_reset(1'b0);
        rdc("status", FOP_REG_STATUS, 32'h3F, 32'h0A, 2'h0);
        do_reset(1'b1);
        rdc("status", FOP_REG_STATUS, 32'h3F, 32'h02, 2'h0);
        cmd(FOP_CMD_OPT_ERASE, FOP_OPT_BASE_ADDR, 8'h00, 2'h0, 0);
        do_reset(1'b1);
        debug_connected <= 1'b1;
        n = 0;
        while (!flash_detach) guard(n);
        debug_connected <= 1'b0;
        do_reset(1'b0);
        chk("detach", 32'h1, {31'h0, flash_detach});
        tally_and_finish();
    end
endmodule
